/* File: design/sector_host_regs.vh */
`ifndef SECTOR_HOST_REGS_VH
`define SECTOR_HOST_REGS_VH
// ****************************************
// Register addresses
// ****************************************
`define REG_HEAD_SELECT_LOAD_TRIGGER 8'h3D
`define REG_DRIVE_SELECT_LOAD_TRIGGER 8'h3E
`define REG_SECTOR_NUMBER 8'h20
`define REG_SECTOR_COUNT 8'h21
`define REG_COMMAND 8'h22
// ****************************************
// Command fields
// ****************************************
`define CMD_START_BIT 0
`define CMD_WRITE_BIT 1
// ****************************************
// Status fields
// ****************************************
`define STAT_BUSY_BIT 0
`define STAT_ERROR_BIT 1
`define STAT_TRACK_END_BIT 2
`define STAT_COUNT_ZERO_BIT 3
`define STAT_WRITE_BIT 4
// ****************************************
// Reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_POINTER 8'h00
// ****************************************
// Timing
// ****************************************
`define RESET_MIN_NS 100
`define CLK_PERIOD_NS 8
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: design/sector_stepper.v */
`timescale 1ns/1ps
`default_nettype none
`include "sector_host_regs.vh"
module sector_stepper #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire load_sector,
	input wire load_count,
	input wire [WIDTH-1:0] din,
	input wire step,
	output reg [WIDTH-1:0] sector,
	output reg [WIDTH-1:0] count
);
	// ****************************************
	// Sector number and remaining count
	// ****************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sector <= {WIDTH{1'b0}};
			count <= {WIDTH{1'b0}};
		end else if (ce) begin
			if (load_sector) begin
				sector <= din;
			end else if (step) begin
				sector <= sector + {{(WIDTH-1){1'b0}}, 1'b1}; // [R03]
			end
			if (load_count) begin
				count <= din;
			end else if (step && count != {WIDTH{1'b0}}) begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1}; // [R03]
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/sector_host_port.v */
// Contract
// R01: Multi-sector read begins at the sector number the host loaded.
// R02: Only data-field bytes go to memory; ID and check bytes stay inside.
// R03: After each sector, sector number plus one and count minus one.
// R04: Stop on count reaching zero, end of track, or error.
// R05: One 8-bit shared bus; driven values change only on rising clock.
// R06: Write to address 3D pulses the head-select strobe.
// R07: Write to address 3E pulses the drive-select strobe.
// R08: Busy high during disk read or write, low when it ends.
// R09: System holds reset low at least 100 ns, power-on use only.
// R10: Reset aborts any operation and clears all state at once.
// R11: Register accesses travel over the same byte bus as buffer data.
// R12: Host writes registers only in an I/O cycle with select low.
// R13: Write-not-read low means write, high read; ignored unless selected.
// R14: Port select low reaches pointer or status, high the pointed register.
// R15: Every processor and DMA operation is synchronous to the clock.
// R16: Busy falls in the same cycle the sequence halts.
`timescale 1ns/1ps
`default_nettype none
`include "sector_host_regs.vh"
module sector_host_port #(
	parameter WIDTH = 8
) (
	input wire SYS_CLK,
	input wire ARST_N,
	input wire CE,
	input wire DEVICE_SELECT_N,
	input wire WRITE_NOT_READ,
	input wire PORT_SELECT,
	input wire [7:0] DATA_IN,
	output reg [7:0] DATA_OUT,
	output reg DATA_OE,
	input wire DISK_BYTE_VALID,
	input wire DISK_DATA_FIELD,
	input wire [7:0] DISK_BYTE,
	input wire SECTOR_DONE,
	input wire TRACK_END,
	input wire DISK_ERROR,
	input wire MEM_BYTE_VALID,
	output reg XFER_STROBE,
	output reg [7:0] WRITE_DATA,
	output reg WRITE_DATA_VALID,
	output reg [7:0] CUR_SECTOR,
	output reg HEAD_SELECT_STROBE,
	output reg DRIVE_SELECT_STROBE,
	output reg BUSY
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	function is_last;
		input [WIDTH-1:0] cnt;
		begin
			is_last = (cnt <= {{(WIDTH-1){1'b0}}, 1'b1});
		end
	endfunction

	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] pointer;
	reg write_mode;
	reg err_flag;
	reg track_flag;
	reg zero_flag;
	reg next_busy;
	reg halt;
	wire [WIDTH-1:0] sector;
	wire [WIDTH-1:0] count;
	reg [7:0] status;
	wire access;
	wire wr_access;
	wire rd_access;
	wire reg_wr;
	wire start_cmd;
	wire step;
	wire send_byte;
	reg [7:0] rd_value;

	// ****************************************
	// Host bus decode
	// ****************************************
	assign access = CE && !DEVICE_SELECT_N; // [R13] [R15]
	assign wr_access = access && !WRITE_NOT_READ; // [R13]
	assign rd_access = access && WRITE_NOT_READ; // [R13]
	assign reg_wr = wr_access && PORT_SELECT; // [R14]
	assign start_cmd = reg_wr && pointer == `REG_COMMAND && DATA_IN[`CMD_START_BIT]
		&& state == ST_IDLE;
	assign step = state == ST_RUN && SECTOR_DONE;
	assign send_byte = state == ST_RUN && !write_mode && DISK_BYTE_VALID
		&& DISK_DATA_FIELD; // [R02]
	// Status: busy, write mode, and flags of the last halt, the flags cleared at start
	always @* begin
		status = `RST_BYTE;
		status[`STAT_BUSY_BIT] = BUSY;
		status[`STAT_ERROR_BIT] = err_flag;
		status[`STAT_TRACK_END_BIT] = track_flag;
		status[`STAT_COUNT_ZERO_BIT] = zero_flag;
		status[`STAT_WRITE_BIT] = write_mode;
	end

	always @* begin
		rd_value = `RST_BYTE;
		if (!PORT_SELECT) begin
			rd_value = status; // [R14]
		end else begin
			case (pointer)
				`REG_SECTOR_NUMBER: rd_value = sector[7:0];
				`REG_SECTOR_COUNT: rd_value = count[7:0];
				`REG_COMMAND: rd_value = {6'h00, write_mode, BUSY};
				default: rd_value = `RST_BYTE;
			endcase
		end
	end

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pointer <= `RST_POINTER;
			HEAD_SELECT_STROBE <= 1'b0;
			DRIVE_SELECT_STROBE <= 1'b0;
		end else if (CE) begin
			HEAD_SELECT_STROBE <= reg_wr && pointer == `REG_HEAD_SELECT_LOAD_TRIGGER; // [R06]
			DRIVE_SELECT_STROBE <= reg_wr && pointer == `REG_DRIVE_SELECT_LOAD_TRIGGER; // [R07]
			if (wr_access && !PORT_SELECT) begin
				pointer <= DATA_IN; // [R14]
			end
		end
	end

	sector_stepper #(
		.WIDTH(WIDTH)
	) u_stepper (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.ce(CE),
		.load_sector(reg_wr && pointer == `REG_SECTOR_NUMBER && state == ST_IDLE), // [R01]
		.load_count(reg_wr && pointer == `REG_SECTOR_COUNT && state == ST_IDLE),
		.din(DATA_IN[WIDTH-1:0]),
		.step(step), // [R03]
		.sector(sector),
		.count(count)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		next_state = state;
		next_busy = BUSY;
		halt = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start_cmd) begin
					next_state = ST_RUN;
					next_busy = 1'b1; // [R08]
				end
			end
			ST_RUN: begin
				halt = DISK_ERROR || TRACK_END || (step && is_last(count))
					|| count == {WIDTH{1'b0}}; // [R04]
				if (halt) begin
					next_state = ST_IDLE;
					next_busy = 1'b0; // [R08] [R16]
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= ST_IDLE; // [R10]
			BUSY <= 1'b0; // [R10]
			write_mode <= 1'b0;
			err_flag <= 1'b0;
			track_flag <= 1'b0;
			zero_flag <= 1'b0;
			CUR_SECTOR <= `RST_BYTE;
		end else if (CE) begin
			state <= next_state;
			BUSY <= next_busy;
			CUR_SECTOR <= sector[7:0];
			if (start_cmd) begin
				write_mode <= DATA_IN[`CMD_WRITE_BIT];
				err_flag <= 1'b0;
				track_flag <= 1'b0;
				zero_flag <= 1'b0;
			end else if (halt) begin
				err_flag <= DISK_ERROR; // [R04]
				track_flag <= TRACK_END;
				zero_flag <= (step && is_last(count)) || count == {WIDTH{1'b0}};
			end
		end
	end

	// ****************************************
	// Shared byte bus and write data
	// ****************************************
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DATA_OUT <= `RST_BYTE;
			DATA_OE <= 1'b0;
			XFER_STROBE <= 1'b0;
			WRITE_DATA <= `RST_BYTE;
			WRITE_DATA_VALID <= 1'b0;
		end else if (CE) begin
			XFER_STROBE <= send_byte;
			WRITE_DATA_VALID <= 1'b0;
			if (send_byte) begin
				DATA_OUT <= DISK_BYTE; // [R02] [R05] [R11]
				DATA_OE <= 1'b1;
			end else if (rd_access) begin
				DATA_OUT <= rd_value; // [R05] [R11]
				DATA_OE <= 1'b1;
			end else begin
				DATA_OE <= 1'b0;
			end
			if (state == ST_RUN && write_mode && MEM_BYTE_VALID) begin
				WRITE_DATA <= DATA_IN; // [R15]
				WRITE_DATA_VALID <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/sector_host_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sector_host_port_chk (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic CE,
	input wire logic DEVICE_SELECT_N,
	input wire logic WRITE_NOT_READ,
	input wire logic PORT_SELECT,
	input wire logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE,
	input wire logic DISK_BYTE_VALID,
	input wire logic DISK_DATA_FIELD,
	input wire logic [7:0] DISK_BYTE,
	input wire logic TRACK_END,
	input wire logic DISK_ERROR,
	input wire logic MEM_BYTE_VALID,
	input wire logic XFER_STROBE,
	input wire logic [7:0] WRITE_DATA,
	input wire logic WRITE_DATA_VALID,
	input wire logic HEAD_SELECT_STROBE,
	input wire logic DRIVE_SELECT_STROBE,
	input wire logic BUSY
);
	// ****************
	// Port checks
	// ****************
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	wire wr = CE && !DEVICE_SELECT_N && !WRITE_NOT_READ;
	wire rd = CE && !DEVICE_SELECT_N && WRITE_NOT_READ;
	logic [7:0] ptr_seen;
	logic wmode;
	// Mirror of the pointer and of the mode of the running command
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ptr_seen <= 8'h00;
			wmode <= 1'b0;
		end else begin
			if (wr && !PORT_SELECT) begin
				ptr_seen <= DATA_IN;
			end
			if (wr && PORT_SELECT && ptr_seen == 8'h22 && DATA_IN[0] && !BUSY) begin
				wmode <= DATA_IN[1];
			end
		end
	end
	// Pointer write followed by a data write
	sequence s_ptr(a);
		wr && !PORT_SELECT && DATA_IN == a ##1 wr && PORT_SELECT;
	endsequence
	head_strobe_a: assert property (s_ptr(8'h3D) |=> HEAD_SELECT_STROBE)
		else $error("head strobe missing");
	drive_strobe_a: assert property (s_ptr(8'h3E) |=> DRIVE_SELECT_STROBE)
		else $error("drive strobe missing");
	strobe_cause_a: assert property (HEAD_SELECT_STROBE |-> $past(wr && PORT_SELECT))
		else $error("head strobe without write");
	busy_start_a: assert property (s_ptr(8'h22) ##0 DATA_IN[0] && !BUSY |=> BUSY)
		else $error("busy not raised");
	busy_halt_a: assert property (BUSY && (TRACK_END || DISK_ERROR) |=> !BUSY)
		else $error("busy not dropped");
	data_xfer_a: assert property (BUSY && !wmode && DISK_BYTE_VALID && DISK_DATA_FIELD |=> XFER_STROBE)
		else $error("data byte not passed");
	id_hidden_a: assert property (XFER_STROBE |-> $past(DISK_DATA_FIELD))
		else $error("non data byte passed");
	read_answer_a: assert property (rd && !BUSY |=> DATA_OE)
		else $error("read not answered");
	drive_cause_a: assert property (DRIVE_SELECT_STROBE |-> $past(wr && PORT_SELECT))
		else $error("drive strobe without write");
	xfer_byte_a: assert property (XFER_STROBE |-> DATA_OE && DATA_OUT == $past(DISK_BYTE))
		else $error("passed byte differs");
	write_capture_a: assert property (BUSY && wmode && MEM_BYTE_VALID
		|=> WRITE_DATA_VALID && WRITE_DATA == $past(DATA_IN))
		else $error("write byte not captured");
endmodule
bind sector_host_port sector_host_port_chk i_chk (
	.SYS_CLK(SYS_CLK),
	.ARST_N(ARST_N),
	.CE(CE),
	.DEVICE_SELECT_N(DEVICE_SELECT_N),
	.WRITE_NOT_READ(WRITE_NOT_READ),
	.PORT_SELECT(PORT_SELECT),
	.DATA_IN(DATA_IN),
	.DATA_OUT(DATA_OUT),
	.DATA_OE(DATA_OE),
	.DISK_BYTE_VALID(DISK_BYTE_VALID),
	.DISK_DATA_FIELD(DISK_DATA_FIELD),
	.DISK_BYTE(DISK_BYTE),
	.TRACK_END(TRACK_END),
	.DISK_ERROR(DISK_ERROR),
	.MEM_BYTE_VALID(MEM_BYTE_VALID),
	.XFER_STROBE(XFER_STROBE),
	.WRITE_DATA(WRITE_DATA),
	.WRITE_DATA_VALID(WRITE_DATA_VALID),
	.HEAD_SELECT_STROBE(HEAD_SELECT_STROBE),
	.DRIVE_SELECT_STROBE(DRIVE_SELECT_STROBE),
	.BUSY(BUSY)
);
`default_nettype wire

/* File: test/buffer_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module buffer_sink (
	input wire logic clk,
	input wire logic oe,
	input wire logic strobe,
	input wire logic [7:0] data
);
	logic [7:0] got[$];
	// Buffer side takes bytes off the shared bus
	always @(posedge clk) begin
		if (strobe && oe) begin
			got.push_back(data);
		end
	end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sector_host_regs.vh"
module testbench;
	logic clk = 0, rst_n = 0, sel_n = 1, wnr = 1, ps = 0;
	logic dv = 0, df = 0, sd = 0, te = 0, de = 0, oe, xs, hs, ds, busy;
	logic [7:0] din = 8'h00, db = 8'h00, dout, cs;
	logic ce = 1, mv = 0, wdv;
	logic [7:0] wd;
	int bad_count = 0, n_compared = 0;
	always #4 clk = ~clk;
	sector_host_port #(.WIDTH(8)) i_dut (.SYS_CLK(clk), .ARST_N(rst_n), .CE(ce),
		.DEVICE_SELECT_N(sel_n), .WRITE_NOT_READ(wnr), .PORT_SELECT(ps), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE(oe), .DISK_BYTE_VALID(dv), .DISK_DATA_FIELD(df),
		.DISK_BYTE(db), .SECTOR_DONE(sd), .TRACK_END(te), .DISK_ERROR(de),
		.MEM_BYTE_VALID(mv), .XFER_STROBE(xs), .WRITE_DATA(wd), .WRITE_DATA_VALID(wdv),
		.CUR_SECTOR(cs), .HEAD_SELECT_STROBE(hs), .DRIVE_SELECT_STROBE(ds), .BUSY(busy));
	buffer_sink i_buf (.clk(clk), .oe(oe), .strobe(xs), .data(dout));
	// ****************
	// Tasks
	// ****************
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task acc(input logic r, input logic p, input logic [7:0] d);
		@(posedge clk);
		sel_n <= 0;
		wnr <= r;
		ps <= p;
		din <= d;
	endtask
	task idle();
		@(posedge clk);
		sel_n <= 1;
		#1;
	endtask
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		acc(0, 0, a);
		acc(0, 1, d);
		idle();
	endtask
	task disk(input logic v, f, s, t, e, input logic [7:0] b);
		@(posedge clk);
		{dv, df, sd, te, de, db} <= {v, f, s, t, e, b};
		@(posedge clk);
		{dv, df, sd, te, de} <= 5'h00;
		#1;
	endtask
	task mem(input logic [7:0] b);
		@(posedge clk);
		mv <= 1;
		din <= b;
		@(posedge clk);
		mv <= 0;
		#1;
	endtask
	task finish_test();
		if (bad_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		fork
			begin
				#100000;
				bad_count++;
				finish_test();
			end
		join_none
		repeat (`RESET_MIN_CYCLES) @(posedge clk);
		rst_n <= 1;
		reg_wr(8'h3D, 8'h03);
		chk_bit(hs, 1);
		chk_bit(ds, 0);
		idle();
		chk_bit(hs, 0);
		reg_wr(8'h3E, 8'h01);
		chk_bit(ds, 1);
		reg_wr(8'h20, 8'h05);
		reg_wr(8'h21, 8'h02);
		reg_wr(8'h22, 8'h01);
		chk_bit(busy, 1);
		disk(1, 1, 0, 0, 0, 8'hA5);
		chk_byte(dout, 8'hA5);
		disk(1, 0, 0, 0, 0, 8'h3C);
		chk_bit(xs, 0);
		disk(1, 1, 0, 0, 0, 8'h5A);
		disk(0, 0, 1, 0, 0, 8'h00);
		idle();
		chk_byte(cs, 8'h06);
		chk_bit(busy, 1);
		disk(0, 0, 1, 0, 0, 8'h00);
		chk_bit(busy, 0);
		acc(1, 0, 8'h00);
		idle();
		chk_byte(dout, 8'h08);
		chk_byte(cs, 8'h07);
		chk_byte(8'(i_buf.got.size()), 8'h02);
		chk_byte(i_buf.got[1], 8'h5A);
		for (int i = 0; i < 2; i++) begin
			reg_wr(8'h21, 8'h05);
			reg_wr(8'h22, 8'h01);
			disk(0, 0, 0, i == 0, i == 1, 8'h00);
			chk_bit(busy, 0);
			acc(1, 0, 8'h00);
			idle();
			chk_byte(dout, i ? 8'h02 : 8'h04);
		end
		acc(0, 0, 8'h30);
		acc(1, 1, 8'h00);
		idle();
		chk_bit(oe, 1);
		chk_byte(dout, 8'h00);
		reg_wr(8'h21, 8'h01);
		reg_wr(8'h22, 8'h03);
		mem(8'hC3);
		chk_byte(wd, 8'hC3);
		chk_bit(wdv, 1);
		disk(1, 1, 0, 0, 0, 8'h77);
		chk_bit(xs, 0);
		chk_bit(wdv, 0);
		disk(0, 0, 1, 0, 0, 8'h00);
		chk_bit(busy, 0);
		acc(1, 0, 8'h00);
		idle();
		chk_byte(dout, 8'h18);
		chk_byte(8'(i_buf.got.size()), 8'h02);
		acc(0, 0, 8'h20);
		acc(1, 1, 8'h00);
		idle();
		chk_byte(dout, 8'h08);
		@(posedge clk);
		ce <= 0;
		reg_wr(8'h3D, 8'h01);
		chk_bit(hs, 0);
		@(posedge clk);
		ce <= 1;
		reg_wr(8'h21, 8'h03);
		reg_wr(8'h22, 8'h01);
		chk_bit(busy, 1);
		@(posedge clk);
		rst_n <= 0;
		#1 chk_bit(busy, 0);
		repeat (`RESET_MIN_CYCLES) @(posedge clk);
		rst_n <= 1;
		idle();
		chk_byte(cs, 8'h00);
		acc(1, 0, 8'h00);
		idle();
		chk_bit(oe, 1);
		chk_byte(dout, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
